/* design/ltp_target.sv */
// Serial two-wire target port: address match, register pointer, write buffer, reads
// Notes on behaviour
// - First byte is seven address bits then direction bit, zero writes, one reads.
// - Only addresses whose top three bits are binary 100 are answered.
// - Straps give ground 00, clock 01, data 10, supply 11; bits 2:1 and 4:3.
// - Clock rate up to 1 MHz; controller never clocks faster.
// - Data sampled while clock is high; idle data line stays high.
// - Data falling while clock high is a start; address compare begins.
// - On matching address the device holds data low through the ninth pulse.
// - Register address byte follows, MSB first, and the device acknowledges it.
// - Write data bytes MSB first; the device acknowledges each data byte that the write buffer has room for.
// - Data rising while clock high is a stop; device waits for next start.
// - Pointer increments by one during each data byte acknowledge.
// - Read: write pointer, repeated start, address with read bit, device drives data.
// - Every register returns its contents when read.
// - Clock is input only; data line is only pulled low or released.
module ltp_target
    import ltp_pkg::*;
#(
    parameter int FIFO_DEPTH = LTP_FIFO_DEPTH
)
(
    input wire logic clk, // System clock, 125 MHz
    input wire logic rst, // Async reset, high
    input wire logic scl_i, // Serial clock pin
    input wire logic sda_i, // Serial data pin level
    output logic sda_o, // Serial data drive value
    output logic sda_oe, // Serial data pull-low enable
    input wire logic strap_pin_low_pair, // Strap for address bits 2:1
    input wire logic strap_pin_high_pair, // Strap for address bits 4:3
    output logic wr_valid, // Buffered register write waiting
    input wire logic wr_ready, // Register map takes write
    output logic [LTP_BYTE_W-1:0] wr_addr, // Write register index
    output logic [LTP_BYTE_W-1:0] wr_data, // Write register value
    output logic [LTP_BYTE_W-1:0] rd_addr, // Read register index
    input wire logic [LTP_BYTE_W-1:0] rd_data // Register value at rd_addr
);

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    logic [3:0] meta_reg;
    logic [3:0] sync_reg;
    logic scl_d_reg;
    logic sda_d_reg;
    logic scl_s;
    logic sda_s;
    logic s1_s;
    logic s2_s;

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            meta_reg <= 4'hf;
            sync_reg <= 4'hf;
            scl_d_reg <= 1'b1;
            sda_d_reg <= 1'b1;
        end
        else
        begin
            meta_reg <= {strap_pin_high_pair, strap_pin_low_pair, sda_i, scl_i};
            sync_reg <= meta_reg;
            scl_d_reg <= sync_reg[0];
            sda_d_reg <= sync_reg[1];
        end
    end

    assign scl_s = sync_reg[0];
    assign sda_s = sync_reg[1];
    assign s1_s = sync_reg[2];
    assign s2_s = sync_reg[3];

    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;

    assign scl_rise = scl_s && !scl_d_reg;
    assign scl_fall = !scl_s && scl_d_reg;
    assign start_det = scl_s && scl_d_reg && sda_d_reg && !sda_s;
    assign stop_det = scl_s && scl_d_reg && !sda_d_reg && sda_s;

    // ----------------------------------------------------------------
    // Strap classification
    // ----------------------------------------------------------------
    // A strap tied to a bus wire is only told apart once the bus moves;
    // the start edge and the clock fall after it separate them before the first address compare.
    logic [1:0] seen_low_reg;
    logic [1:0] diff_scl_reg;
    logic [1:0] diff_sda_reg;
    logic [1:0] strap_lvl;

    assign strap_lvl = {s2_s, s1_s};

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            seen_low_reg <= 2'h0;
            diff_scl_reg <= 2'h0;
            diff_sda_reg <= 2'h0;
        end
        else
        begin
            for (int i = 0; i < 2; i++)
            begin
                if (!strap_lvl[i])
                begin
                    seen_low_reg[i] <= 1'b1;
                end
                if (strap_lvl[i] != scl_s)
                begin
                    diff_scl_reg[i] <= 1'b1;
                end
                if (strap_lvl[i] != sda_s)
                begin
                    diff_sda_reg[i] <= 1'b1;
                end
            end
        end
    end

    function automatic logic [1:0] strap_code(input logic seen_low, input logic dscl,
                                              input logic dsda);
        if (!seen_low)
        begin
            strap_code = LTP_STRAP_VCC;
        end
        else if (!dscl)
        begin
            strap_code = LTP_STRAP_SCL;
        end
        else if (!dsda)
        begin
            strap_code = LTP_STRAP_SDA;
        end
        else
        begin
            strap_code = LTP_STRAP_GND;
        end
    endfunction

    logic [LTP_ADDR_W-1:0] own_addr;

    assign own_addr = {LTP_FIXED_BITS,
                       strap_code(seen_low_reg[1], diff_scl_reg[1], diff_sda_reg[1]),
                       strap_code(seen_low_reg[0], diff_scl_reg[0], diff_sda_reg[0])};

    // ----------------------------------------------------------------
    // Write buffer
    // ----------------------------------------------------------------
    logic fifo_in_valid;
    logic fifo_in_ready;
    logic [2*LTP_BYTE_W-1:0] fifo_out_data;
    logic [LTP_BYTE_W-1:0] ptr_reg;
    logic [LTP_BYTE_W-1:0] shift_reg;

    ltp_fifo #(
        .WIDTH(2 * LTP_BYTE_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(clk),
        .rst(rst),
        .in_valid(fifo_in_valid),
        .in_ready(fifo_in_ready),
        .in_data({ptr_reg, shift_reg}),
        .out_valid(wr_valid),
        .out_ready(wr_ready),
        .out_data(fifo_out_data)
    );

    assign wr_addr = fifo_out_data[2*LTP_BYTE_W-1:LTP_BYTE_W];
    assign wr_data = fifo_out_data[LTP_BYTE_W-1:0];

    // ----------------------------------------------------------------
    // Protocol state machine
    // ----------------------------------------------------------------
    ltp_state_e state_reg;
    logic [3:0] bit_cnt_reg;
    logic [LTP_BYTE_W-1:0] tx_reg;
    logic sda_oe_reg;
    logic more_reg;
    logic byte_done;
    logic addr_match;

    assign byte_done = (bit_cnt_reg == LTP_BITS_PER_BYTE);
    assign addr_match = (shift_reg[LTP_BYTE_W-1:1] == own_addr);
    // Push only on the falling edge that opens the acknowledge slot
    assign fifo_in_valid = (state_reg == LTP_WDATA) && scl_fall && byte_done
                           && !start_det && !stop_det;

    // Bit counting and shifting of received bits
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            bit_cnt_reg <= 4'h0;
            shift_reg <= 8'h00;
        end
        else if (start_det || stop_det)
        begin
            bit_cnt_reg <= 4'h0;
        end
        else if (scl_rise && state_reg != LTP_ADDR_ACK)
        begin
            shift_reg <= {shift_reg[LTP_BYTE_W-2:0], sda_s};
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
        end
        else if (scl_fall && (byte_done || state_reg == LTP_ADDR_ACK
                 || state_reg == LTP_REG_ACK || state_reg == LTP_WDATA_ACK
                 || state_reg == LTP_RDATA_ACK))
        begin
            bit_cnt_reg <= 4'h0;
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            state_reg <= LTP_IDLE;
            sda_oe_reg <= 1'b0;
            ptr_reg <= 8'h00;
            tx_reg <= 8'h00;
            more_reg <= 1'b0;
        end
        else if (start_det)
        begin
            state_reg <= LTP_ADDR;
            sda_oe_reg <= 1'b0;
        end
        else if (stop_det)
        begin
            state_reg <= LTP_IDLE;
            sda_oe_reg <= 1'b0;
        end
        else
        begin
            case (state_reg)
                LTP_IDLE:
                begin
                    sda_oe_reg <= 1'b0;
                end
                LTP_ADDR:
                begin
                    if (scl_fall && byte_done)
                    begin
                        if (addr_match)
                        begin
                            sda_oe_reg <= 1'b1;
                            state_reg <= LTP_ADDR_ACK;
                            tx_reg <= rd_data;
                        end
                        else
                        begin
                            state_reg <= LTP_IDLE;
                        end
                    end
                end
                LTP_ADDR_ACK:
                begin
                    if (scl_fall)
                    begin
                        if (shift_reg[LTP_DIR_POS] == LTP_DIR_READ)
                        begin
                            state_reg <= LTP_RDATA;
                            sda_oe_reg <= !tx_reg[LTP_BYTE_W-1];
                        end
                        else
                        begin
                            state_reg <= LTP_REG;
                            sda_oe_reg <= 1'b0;
                        end
                    end
                end
                LTP_REG:
                begin
                    if (scl_fall && byte_done)
                    begin
                        ptr_reg <= shift_reg;
                        sda_oe_reg <= 1'b1;
                        state_reg <= LTP_REG_ACK;
                    end
                end
                LTP_REG_ACK:
                begin
                    if (scl_fall)
                    begin
                        sda_oe_reg <= 1'b0;
                        state_reg <= LTP_WDATA;
                    end
                end
                LTP_WDATA:
                begin
                    if (scl_fall && byte_done)
                    begin
                        // A full buffer refuses the byte rather than lose it
                        if (fifo_in_ready)
                        begin
                            sda_oe_reg <= 1'b1;
                            state_reg <= LTP_WDATA_ACK;
                            ptr_reg <= ptr_reg + 8'h01;
                        end
                        else
                        begin
                            state_reg <= LTP_IDLE;
                        end
                    end
                end
                LTP_WDATA_ACK:
                begin
                    if (scl_fall)
                    begin
                        sda_oe_reg <= 1'b0;
                        state_reg <= LTP_WDATA;
                    end
                end
                LTP_RDATA:
                begin
                    if (scl_fall)
                    begin
                        if (byte_done)
                        begin
                            sda_oe_reg <= 1'b0;
                            state_reg <= LTP_RDATA_ACK;
                        end
                        else
                        begin
                            sda_oe_reg <= !tx_reg[3'(7 - bit_cnt_reg)];
                        end
                    end
                end
                LTP_RDATA_ACK:
                begin
                    if (scl_rise)
                    begin
                        more_reg <= !sda_s;
                        if (!sda_s)
                        begin
                            ptr_reg <= ptr_reg + 8'h01;
                        end
                    end
                    else if (scl_fall)
                    begin
                        if (more_reg)
                        begin
                            tx_reg <= rd_data;
                            sda_oe_reg <= !rd_data[LTP_BYTE_W-1];
                            state_reg <= LTP_RDATA;
                        end
                        else
                        begin
                            state_reg <= LTP_IDLE;
                        end
                    end
                end
                default:
                begin
                    state_reg <= LTP_IDLE;
                    sda_oe_reg <= 1'b0;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    logic sda_o_reg;
    logic [LTP_BYTE_W-1:0] rd_addr_reg;

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            sda_o_reg <= 1'b0;
            rd_addr_reg <= 8'h00;
        end
        else
        begin
            sda_o_reg <= 1'b0;
            rd_addr_reg <= ptr_reg;
        end
    end

    assign sda_o = sda_o_reg;
    assign sda_oe = sda_oe_reg;
    assign rd_addr = rd_addr_reg;

endmodule // ltp_target

/* design/ltp_pkg.sv */
// Constants and types shared by the serial target port files
package ltp_pkg;

    // ----------------------------------------------------------------
    // Address format
    // ----------------------------------------------------------------
    localparam int LTP_ADDR_W = 7;
    localparam int LTP_BYTE_W = 8;
    localparam logic [2:0] LTP_FIXED_BITS = 3'h4;
    localparam int LTP_DIR_POS = 0;
    localparam logic LTP_DIR_WRITE = 1'b0;
    localparam logic LTP_DIR_READ = 1'b1;
    localparam logic [3:0] LTP_BITS_PER_BYTE = 4'h8;

    // ----------------------------------------------------------------
    // Strap codes
    // ----------------------------------------------------------------
    localparam logic [1:0] LTP_STRAP_GND = 2'h0;
    localparam logic [1:0] LTP_STRAP_SCL = 2'h1;
    localparam logic [1:0] LTP_STRAP_SDA = 2'h2;
    localparam logic [1:0] LTP_STRAP_VCC = 2'h3;

    // ----------------------------------------------------------------
    // Timing and buffering
    // ----------------------------------------------------------------
    localparam int LTP_SCL_MAX_KHZ = 1000;
    localparam int LTP_FIFO_DEPTH = 16;
    localparam int LTP_SYNC_STAGES = 2;

    typedef enum logic [3:0] {
        LTP_IDLE      = 4'h0,
        LTP_ADDR      = 4'h1,
        LTP_ADDR_ACK  = 4'h2,
        LTP_REG       = 4'h3,
        LTP_REG_ACK   = 4'h4,
        LTP_WDATA     = 4'h5,
        LTP_WDATA_ACK = 4'h6,
        LTP_RDATA     = 4'h7,
        LTP_RDATA_ACK = 4'h8
    } ltp_state_e;

endpackage

/* design/ltp_fifo.sv */
// Write buffer between the serial port and the register map
module ltp_fifo
    import ltp_pkg::*;
#(
    parameter int WIDTH = 16,
    parameter int DEPTH = LTP_FIFO_DEPTH
)
(
    input wire logic clk, // System clock
    input wire logic rst, // Async reset, high
    input wire logic in_valid, // Word offered
    output logic in_ready, // Room for a word
    input wire logic [WIDTH-1:0] in_data, // Word in
    output logic out_valid, // Word waiting, from flop
    input wire logic out_ready, // Consumer takes word
    output logic [WIDTH-1:0] out_data // Word out, from flop
);

    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0] wr_ptr_reg;
    logic [PW-1:0] rd_ptr_reg;
    logic [PW:0] cnt_reg;
    logic out_valid_reg;
    logic [WIDTH-1:0] out_data_reg;
    logic push;
    logic pop;

    // Output slot refills from memory; no bypass keeps timing simple
    assign in_ready = (cnt_reg != (PW+1)'(DEPTH));
    assign push = in_valid && in_ready;
    assign pop = (cnt_reg != '0) && (!out_valid_reg || out_ready);
    assign out_valid = out_valid_reg;
    assign out_data = out_data_reg;

    always_ff @(posedge clk)
    begin
        if (push)
        begin
            mem[wr_ptr_reg] <= in_data;
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            cnt_reg <= '0;
        end
        else
        begin
            if (push)
            begin
                wr_ptr_reg <= (wr_ptr_reg == PW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
            end
            if (pop)
            begin
                rd_ptr_reg <= (rd_ptr_reg == PW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
            end
            if (push && !pop)
            begin
                cnt_reg <= cnt_reg + 1'b1;
            end
            else if (pop && !push)
            begin
                cnt_reg <= cnt_reg - 1'b1;
            end
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            out_valid_reg <= 1'b0;
            out_data_reg <= '0;
        end
        else if (pop)
        begin
            out_valid_reg <= 1'b1;
            out_data_reg <= mem[rd_ptr_reg];
        end
        else if (out_ready)
        begin
            out_valid_reg <= 1'b0;
        end
    end

endmodule // ltp_fifo

/* tb/ltp_target_props.sv */
// Pin and write buffer checks for the serial target port
module ltp_target_props
    import ltp_pkg::*;
#(
    parameter int FIFO_DEPTH = LTP_FIFO_DEPTH
)
(
    input wire logic clk, // System clock
    input wire logic rst, // Async reset, high
    input wire logic scl_i, // Serial clock pin
    input wire logic sda_i, // Data wire level
    input wire logic sda_o, // Data drive value
    input wire logic sda_oe, // Data pull-low enable
    input wire logic strap_pin_low_pair, // Strap, bits 2:1
    input wire logic strap_pin_high_pair, // Strap, bits 4:3
    input wire logic wr_valid, // Buffered write waiting
    input wire logic wr_ready, // Map takes write
    input wire logic [LTP_BYTE_W-1:0] wr_addr, // Write index
    input wire logic [LTP_BYTE_W-1:0] wr_data, // Write value
    input wire logic [LTP_BYTE_W-1:0] rd_addr, // Read index
    input wire logic [LTP_BYTE_W-1:0] rd_data // Read value
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    property p_drive_low_only;
        sda_oe |-> sda_o == 1'b0;
    endproperty
    a_drive_low_only: assert property (p_drive_low_only)
        else $error("data line driven high");

    property p_quiet_after_reset;
        $fell(rst) |-> (!sda_oe) [*4];
    endproperty
    a_quiet_after_reset: assert property (p_quiet_after_reset)
        else $error("data pulled low right after reset");

    // Device edges must follow a clock fall, never sit in the high phase
    property p_ack_rise_clk_low;
        $rose(sda_oe) |-> !scl_i && ($past(scl_i, 3) || $past(scl_i, 4) || $past(scl_i, 5));
    endproperty
    a_ack_rise_clk_low: assert property (p_ack_rise_clk_low)
        else $error("pull-low began outside the low clock phase");

    property p_ack_fall_clk_low;
        $fell(sda_oe) |-> !scl_i && !$past(scl_i, 1) && !$past(scl_i, 2);
    endproperty
    a_ack_fall_clk_low: assert property (p_ack_fall_clk_low)
        else $error("data released while clock high");

    property p_idle_after_stop;
        $rose(sda_i) && scl_i && $past(scl_i) |-> (!sda_oe) [*8];
    endproperty
    a_idle_after_stop: assert property (p_idle_after_stop)
        else $error("data pulled low after stop");

    property p_buffer_hold;
        wr_valid && !wr_ready |=> wr_valid && $stable(wr_addr) && $stable(wr_data);
    endproperty
    a_buffer_hold: assert property (p_buffer_hold)
        else $error("buffered write changed before taken");

    property p_push_on_clk_low;
        $rose(wr_valid) |-> !scl_i;
    endproperty
    a_push_on_clk_low: assert property (p_push_on_clk_low)
        else $error("write word appeared during clock high");

    property p_drop_only_taken;
        $fell(wr_valid) |-> $past(wr_ready);
    endproperty
    a_drop_only_taken: assert property (p_drop_only_taken)
        else $error("write word vanished untaken");
endmodule // ltp_target_props

bind ltp_target ltp_target_props #(.FIFO_DEPTH(FIFO_DEPTH)) i_props (.clk(clk), .rst(rst),
    .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe),
    .strap_pin_low_pair(strap_pin_low_pair), .strap_pin_high_pair(strap_pin_high_pair),
    .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_addr(wr_addr), .wr_data(wr_data),
    .rd_addr(rd_addr), .rd_data(rd_data));

/* tb/ltp_host_model.sv */
// Bus controller model: drives the serial clock and pulls the data wire
module ltp_host_model
#(
    parameter int QUARTER = 33
)
(
    input wire logic clk, // Bench clock, paces bit timing
    input wire logic sda_i, // Resolved data wire
    output logic scl_o, // Serial clock, high when idle
    output logic sda_low_o // High pulls data wire low
);
    timeunit 1ns;
    timeprecision 1ps;

    initial
    begin
        scl_o = 1'b1;
        sda_low_o = 1'b0;
    end

    // Four quarters of 264 ns keep the clock just under 1 MHz
    task automatic quarter;
        repeat (QUARTER) @(negedge clk);
    endtask

    // Also serves as repeated start from a low clock
    task automatic start;
        sda_low_o = 1'b0;
        quarter();
        scl_o = 1'b1;
        quarter();
        sda_low_o = 1'b1;
        quarter();
        scl_o = 1'b0;
        quarter();
    endtask

    task automatic stop;
        sda_low_o = 1'b1;
        quarter();
        scl_o = 1'b1;
        quarter();
        sda_low_o = 1'b0;
        quarter();
        quarter();
    endtask

    task automatic bit_io(input logic tx, output logic rx);
        sda_low_o = !tx;
        quarter();
        scl_o = 1'b1;
        quarter();
        rx = sda_i;
        quarter();
        scl_o = 1'b0;
        quarter();
    endtask

    task automatic xfer(input logic [7:0] tx, input logic ack_tx, output logic [7:0] rx,
        output logic ack_rx);
        for (int i = 7; i >= 0; i--)
            bit_io(tx[i], rx[i]);
        bit_io(ack_tx, ack_rx);
    endtask
endmodule // ltp_host_model

/* tb/ltp_target_bench.sv */
// Self-checking bench for the serial target port
module ltp_target_bench
    import ltp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [6:0] OWN_ADDR = {LTP_FIXED_BITS, LTP_STRAP_VCC, LTP_STRAP_GND};

    logic clk;
    logic rst;
    logic scl;
    logic host_low;
    logic sda_wire;
    logic sda_o;
    logic sda_oe;
    logic strap_lo;
    logic strap_hi;
    logic wr_valid;
    logic wr_ready;
    logic [LTP_BYTE_W-1:0] wr_addr;
    logic [LTP_BYTE_W-1:0] wr_data;
    logic [LTP_BYTE_W-1:0] rd_addr;
    logic [LTP_BYTE_W-1:0] rd_data;
    logic [LTP_BYTE_W-1:0] reg_map [256];
    int taken;
    int bad_count;
    int total_checks;

    // ----------------------------------------------------------------
    // Wire, register map and instances
    // ----------------------------------------------------------------
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    assign sda_wire = !(host_low || sda_oe);
    assign rd_data = reg_map[rd_addr];

    always @(posedge clk)
    begin
        if (rst)
        begin
            taken <= 0;
            for (int i = 0; i < 256; i++)
                reg_map[i] <= 8'h00;
        end
        else if (wr_valid === 1'b1 && wr_ready === 1'b1)
        begin
            reg_map[wr_addr] <= wr_data;
            taken <= taken + 1;
        end
    end

    ltp_target #(.FIFO_DEPTH(LTP_FIFO_DEPTH)) i_dut (.clk(clk), .rst(rst), .scl_i(scl),
        .sda_i(sda_wire), .sda_o(sda_o), .sda_oe(sda_oe), .strap_pin_low_pair(strap_lo),
        .strap_pin_high_pair(strap_hi), .wr_valid(wr_valid), .wr_ready(wr_ready),
        .wr_addr(wr_addr), .wr_data(wr_data), .rd_addr(rd_addr), .rd_data(rd_data));

    ltp_host_model #(.QUARTER(33)) i_host (.clk(clk), .sda_i(sda_wire), .scl_o(scl),
        .sda_low_o(host_low));

    // ----------------------------------------------------------------
    // Helpers and scenarios
    // ----------------------------------------------------------------
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic test_done;
        $display("Checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    function automatic logic [7:0] wdat(input logic [7:0] a);
        return a ^ 8'h5a;
    endfunction

    // Ack comes back as 0 on the wire
    task automatic send(input logic [7:0] b, output logic ack);
        logic [7:0] rx;
        i_host.xfer(b, 1'b1, rx, ack);
    endtask

    task automatic t_address;
        logic [6:0] addrs [5];
        logic ack;
        addrs = '{OWN_ADDR, OWN_ADDR ^ 7'h01, OWN_ADDR ^ 7'h08,
                  OWN_ADDR ^ 7'h40, OWN_ADDR ^ 7'h10};
        for (int i = 0; i < 5; i++)
        begin
            i_host.start();
            send({addrs[i], LTP_DIR_WRITE}, ack);
            check({15'h0, ack}, {15'h0, i != 0});
            if (i != 0)
            begin
                send(8'h00, ack);
                check({15'h0, ack}, 16'h1);
            end
            i_host.stop();
        end
        repeat (10) @(negedge clk);
        check({15'h0, wr_valid}, 16'h0);
        $display("test address done");
    endtask

    task automatic t_write(input logic [7:0] base, input int n);
        logic ack;
        wr_ready = 1'b1;
        i_host.start();
        send({OWN_ADDR, LTP_DIR_WRITE}, ack);
        check({15'h0, ack}, 16'h0);
        send(base, ack);
        check({15'h0, ack}, 16'h0);
        for (int i = 0; i < n; i++)
        begin
            send(wdat(base + i[7:0]), ack);
            check({15'h0, ack}, 16'h0);
        end
        i_host.stop();
        repeat (8) @(negedge clk);
        for (int i = 0; i < n; i++)
            check({8'h0, reg_map[base + i[7:0]]}, {8'h0, wdat(base + i[7:0])});
        $display("test write done");
    endtask

    task automatic t_read(input logic [7:0] base, input int n);
        logic ack;
        logic [7:0] rx;
        i_host.start();
        send({OWN_ADDR, LTP_DIR_WRITE}, ack);
        send(base, ack);
        check({15'h0, ack}, 16'h0);
        i_host.start();
        send({OWN_ADDR, LTP_DIR_READ}, ack);
        check({15'h0, ack}, 16'h0);
        for (int i = 0; i < n; i++)
        begin
            i_host.xfer(8'hff, i == n - 1, rx, ack);
            check({8'h0, rx}, {8'h0, wdat(base + i[7:0])});
        end
        i_host.stop();
        $display("test read done");
    endtask

    // Register map stalls so the buffer fills to its output slot plus depth
    task automatic t_full;
        logic ack;
        int t0;
        wr_ready = 1'b0;
        t0 = taken;
        i_host.start();
        send({OWN_ADDR, LTP_DIR_WRITE}, ack);
        send(8'h40, ack);
        for (int i = 0; i <= LTP_FIFO_DEPTH + 1; i++)
        begin
            send(wdat(8'h40 + i[7:0]), ack);
            check({15'h0, ack}, {15'h0, i > LTP_FIFO_DEPTH});
        end
        i_host.stop();
        check({wr_addr, wr_data}, {8'h40, wdat(8'h40)});
        wr_ready = 1'b1;
        for (int k = 0; k < 100 && wr_valid !== 1'b0; k++)
            @(negedge clk);
        check(16'(taken - t0), 16'(LTP_FIFO_DEPTH + 1));
        for (int i = 0; i <= LTP_FIFO_DEPTH + 1; i++)
            check({8'h0, reg_map[8'h40 + i[7:0]]},
                  {8'h0, i > LTP_FIFO_DEPTH ? 8'h00 : wdat(8'h40 + i[7:0])});
        $display("test full done");
    endtask

    // ----------------------------------------------------------------
    // Main sequence and watchdog
    // ----------------------------------------------------------------
    initial
    begin
        rst = 1'b1;
        wr_ready = 1'b0;
        strap_lo = 1'b0;
        strap_hi = 1'b1;
        bad_count = 0;
        total_checks = 0;
        repeat (10) @(negedge clk);
        rst = 1'b0;
        repeat (8) @(negedge clk);
        check({13'h0, sda_o, sda_oe, wr_valid}, 16'h0);
        check({8'h0, rd_addr}, 16'h0);
        $display("test reset done");
        t_address();
        t_write(8'h10, 3);
        t_write(8'hff, 2);
        t_read(8'h10, 3);
        t_read(8'hff, 2);
        t_full();
        test_done();
    end

    initial
    begin
        repeat (90000) @(posedge clk);
        bad_count++;
        $display("Watchdog expired at %0t", $time);
        test_done();
    end
endmodule // ltp_target_bench
